//--- rtl/vsrf_fifo.sv
// Single-clock FIFO with synchronous clear and registered read data
`timescale 1ns/100ps
module vsrf_fifo
  import vsrf_pkg::*;
#(
  parameter int WIDTH = WORD_BITS,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clear,
  input wire logic wr_valid,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic rd_pop,
  output logic [WIDTH-1:0] rd_data,
  output logic [$clog2(DEPTH):0] level,
  output logic full,
  output logic empty
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [AW:0] level_reg, level_next;
  logic [WIDTH-1:0] rd_data_reg, rd_data_next;
  logic do_wr, do_rd;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  assign full = (level_reg == (AW+1)'(DEPTH));
  assign empty = (level_reg == '0);
  // Overfill is dropped rather than wrapping; timing must prevent it
  assign do_wr = wr_valid && !full;
  assign do_rd = rd_pop && !empty;

  // Pointer and level update
  always_comb begin
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    level_next = level_reg;
    rd_data_next = rd_data_reg;
    if (do_wr) begin
      wr_ptr_next = wr_ptr_reg + 1'b1;
    end
    if (do_rd) begin
      rd_ptr_next = rd_ptr_reg + 1'b1;
      rd_data_next = mem[rd_ptr_reg];
    end
    if (do_wr && !do_rd) begin
      level_next = level_reg + 1'b1;
    end else if (do_rd && !do_wr) begin
      level_next = level_reg - 1'b1;
    end
    if (clear) begin
      wr_ptr_next = '0;
      rd_ptr_next = '0;
      level_next = '0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      level_reg <= '0;
      rd_data_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      level_reg <= level_next;
      rd_data_reg <= rd_data_next;
    end
  end

  // Storage array, no reset needed
  always_ff @(posedge clk_sys) begin
    if (do_wr && !clear) begin
      mem[wr_ptr_reg] <= wr_data;
    end
  end

  assign rd_data = rd_data_reg;
  assign level = level_reg;

endmodule : vsrf_fifo

//--- rtl/vsrf_pkg.sv
// Shared constants and types for the video RAM serial read FIFO block
package vsrf_pkg;

  // ----------------------------------------------------------------
  // Data shapes
  // ----------------------------------------------------------------
  localparam int LANE_COUNT = 8;
  localparam int LANE_BITS = 8;
  localparam int WORD_BITS = LANE_COUNT * LANE_BITS;
  localparam int FIFO_DEPTH = 8;
  localparam int COLOUR_BITS = 8;
  localparam int OVERLAY_BITS = 4;

  // ----------------------------------------------------------------
  // Timing counts, in half-dot-clock cycles unless noted
  // ----------------------------------------------------------------
  localparam logic [2:0] FETCH_LATENCY = 3'h7;
  localparam logic [1:0] UNLOAD_LATENCY = 2'h2;
  localparam logic [2:0] DIV_LAST = 3'h4;
  localparam logic [2:0] DIV_TICK_A = 3'h0;
  localparam logic [2:0] DIV_TICK_B = 3'h2;
  localparam logic [3:0] OVERLAY_READS = 4'h4;
  localparam logic [3:0] GROUP_SKIP_SLOT = 4'hc;
  localparam logic [2:0] READ_PHASE_COLOUR_B = 3'h4;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [OVERLAY_BITS-1:0] overlay;
    logic [COLOUR_BITS-1:0] colour;
  } vsrf_pixel_t;

  typedef struct packed {
    logic [LANE_BITS-1:0] d_odd;
    logic [LANE_BITS-1:0] d_even;
    logic [LANE_BITS-1:0] c_odd;
    logic [LANE_BITS-1:0] c_even;
    logic [LANE_BITS-1:0] b_odd;
    logic [LANE_BITS-1:0] b_even;
    logic [LANE_BITS-1:0] a_odd;
    logic [LANE_BITS-1:0] a_even;
  } vsrf_lanes_t;

endpackage : vsrf_pkg

//--- rtl/vsrf_top.sv
// Shift clock generation, fetch sequencing and pixel FIFOs for the VRAM serial read path
`timescale 1ns/100ps
// Notes on behaviour
// - Shift clock is fifth dot clock, derived internally
// - Shift clock runs only while serial gate high
// - Skip one shift pulse after 64 pixels
// - Group is 4 overlay then 8 colour reads
// - Unload gate starts draining and pixel output
// - Separate overlay and colour FIFOs, different rates
// - Each FIFO 64 bits wide, 8 deep
// - Fill levels before blanking; no full protection
// - Fetch starts 7 cycles after serial gate
// - First FIFO read 2 cycles after unload
// - Two identical shift clock outputs
// - Active low reset initialises all state except FIFO storage
// - Two 12-bit pixel ports, per half-dot clock
// - Colour FIFO covers overlay fetch time
// - Eight 8-bit VRAM lanes feed the FIFOs
// - Lanes captured on the sent shift clock
// - Stream: overlay 4 bpp, then colour 8 bpp
module vsrf_top
  import vsrf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic serial_read_gate,
  input wire logic fifo_unload_gate,
  input wire logic [LANE_BITS-1:0] vram_lane_a_even,
  input wire logic [LANE_BITS-1:0] vram_lane_a_odd,
  input wire logic [LANE_BITS-1:0] vram_lane_b_even,
  input wire logic [LANE_BITS-1:0] vram_lane_b_odd,
  input wire logic [LANE_BITS-1:0] vram_lane_c_even,
  input wire logic [LANE_BITS-1:0] vram_lane_c_odd,
  input wire logic [LANE_BITS-1:0] vram_lane_d_even,
  input wire logic [LANE_BITS-1:0] vram_lane_d_odd,
  output logic vram_shift_clock_a,
  output logic vram_shift_clock_b,
  output vsrf_pixel_t merged_pixel_port_even,
  output vsrf_pixel_t merged_pixel_port_odd,
  output logic pixel_valid,
  output logic [3:0] overlay_level,
  output logic [3:0] colour_level
);

  typedef enum logic [1:0] {VSRF_IDLE, VSRF_LATENCY, VSRF_FETCH} vsrf_fetch_state_t;

  // Colour byte of a pixel within a 64-bit word
  function automatic logic [COLOUR_BITS-1:0] vsrf_colour_at(input logic [WORD_BITS-1:0] w, input logic [2:0] i);
    vsrf_colour_at = w[{i, 3'h0} +: COLOUR_BITS];
  endfunction : vsrf_colour_at

  // Overlay nibble of a pixel within a 64-bit word
  function automatic logic [OVERLAY_BITS-1:0] vsrf_overlay_at(input logic [WORD_BITS-1:0] w, input logic [3:0] i);
    vsrf_overlay_at = w[{i, 2'h0} +: OVERLAY_BITS];
  endfunction : vsrf_overlay_at

  // ----------------------------------------------------------------
  // Fetch side state
  // ----------------------------------------------------------------
  vsrf_fetch_state_t fstate_reg, fstate_next;
  logic [2:0] lat_reg, lat_next;
  logic [2:0] div_reg, div_next;
  logic [3:0] slot_reg, slot_next;
  logic shift_reg, shift_next;
  logic [1:0] cap_pipe_reg, cap_pipe_next;
  logic [1:0] ovl_pipe_reg, ovl_pipe_next;
  vsrf_lanes_t lanes_s1_reg, lanes_s2_reg;
  logic div_tick, slot_is_ovl;
  logic ovl_wr, col_wr;
  logic gate_off;

  assign gate_off = !serial_read_gate;
  assign div_tick = (div_reg == DIV_TICK_A) || (div_reg == DIV_TICK_B);
  assign slot_is_ovl = (slot_reg < OVERLAY_READS);

  // Sequencer, divider and group slot counter
  always_comb begin
    fstate_next = fstate_reg;
    lat_next = lat_reg;
    div_next = div_reg;
    slot_next = slot_reg;
    shift_next = 1'b0;
    unique case (fstate_reg)
      VSRF_IDLE: begin
        if (serial_read_gate) begin
          fstate_next = VSRF_LATENCY;
          lat_next = 3'h1;
        end
      end
      VSRF_LATENCY: begin
        lat_next = lat_reg + 3'h1;
        if (lat_reg == FETCH_LATENCY - 3'h1) begin
          fstate_next = VSRF_FETCH;
          div_next = '0;
          slot_next = '0;
        end
      end
      VSRF_FETCH: begin
        div_next = (div_reg == DIV_LAST) ? 3'h0 : div_reg + 3'h1;
        if (div_tick) begin
          // Skip slot withholds the pulse so the FIFOs do not creep up
          shift_next = (slot_reg != GROUP_SKIP_SLOT);
          slot_next = (slot_reg == GROUP_SKIP_SLOT) ? 4'h0 : slot_reg + 4'h1;
        end
      end
    endcase
    if (gate_off) begin
      fstate_next = VSRF_IDLE;
      lat_next = '0;
      div_next = '0;
      slot_next = '0;
      shift_next = 1'b0;
    end
  end

  // Capture pipeline tracks the shift pulse through the lane synchronisers
  always_comb begin
    cap_pipe_next = {cap_pipe_reg[0], shift_reg};
    ovl_pipe_next = ovl_pipe_reg;
    if (shift_next) begin
      ovl_pipe_next = {ovl_pipe_reg[0], slot_is_ovl};
    end else begin
      ovl_pipe_next = {ovl_pipe_reg[0], ovl_pipe_reg[0]};
    end
    if (gate_off) begin
      cap_pipe_next = '0;
      ovl_pipe_next = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      fstate_reg <= VSRF_IDLE;
      lat_reg <= '0;
      div_reg <= '0;
      slot_reg <= '0;
      shift_reg <= 1'b0;
      cap_pipe_reg <= '0;
      ovl_pipe_reg <= '0;
    end else begin
      fstate_reg <= fstate_next;
      lat_reg <= lat_next;
      div_reg <= div_next;
      slot_reg <= slot_next;
      shift_reg <= shift_next;
      cap_pipe_reg <= cap_pipe_next;
      ovl_pipe_reg <= ovl_pipe_next;
    end
  end

  // Two-flop synchronisers on the lane pins
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      lanes_s1_reg <= '0;
      lanes_s2_reg <= '0;
    end else begin
      lanes_s1_reg <= {vram_lane_d_odd, vram_lane_d_even, vram_lane_c_odd, vram_lane_c_even,
                       vram_lane_b_odd, vram_lane_b_even, vram_lane_a_odd, vram_lane_a_even};
      lanes_s2_reg <= lanes_s1_reg;
    end
  end

  // Same pulse that went to the VRAMs, delayed through the synchroniser
  assign ovl_wr = cap_pipe_reg[1] && ovl_pipe_reg[1];
  assign col_wr = cap_pipe_reg[1] && !ovl_pipe_reg[1];
  assign vram_shift_clock_a = shift_reg;
  assign vram_shift_clock_b = shift_reg;

  // ----------------------------------------------------------------
  // Unload side state
  // ----------------------------------------------------------------
  logic [1:0] ulat_reg, ulat_next;
  logic reading_reg, reading_next;
  logic [2:0] rphase_reg, rphase_next;
  logic [2:0] ophase_reg, ophase_next;
  logic ovalid_reg, ovalid_next;
  // Output valid trails read data by one stage, in step with the merge registers
  logic outv_reg, outv_next;
  vsrf_pixel_t even_reg, even_next, odd_reg, odd_next;
  logic ovl_pop, col_pop;
  logic [WORD_BITS-1:0] ovl_word, col_word;
  logic [3:0] ovl_idx;

  assign ovl_pop = reading_reg && (rphase_reg == 3'h0);
  assign col_pop = reading_reg && ((rphase_reg == 3'h0) || (rphase_reg == READ_PHASE_COLOUR_B));
  assign ovl_idx = {ophase_reg, 1'b0};

  // Unload delay, read phase and merge of colour with overlay
  always_comb begin
    ulat_next = ulat_reg;
    reading_next = reading_reg;
    rphase_next = reading_reg ? rphase_reg + 3'h1 : 3'h0;
    ophase_next = rphase_reg;
    ovalid_next = reading_reg;
    outv_next = ovalid_reg;
    even_next = even_reg;
    odd_next = odd_reg;
    if (fifo_unload_gate && !reading_reg) begin
      ulat_next = ulat_reg + 2'h1;
      if (ulat_reg == UNLOAD_LATENCY - 2'h1) begin
        reading_next = 1'b1;
      end
    end
    if (ovalid_reg) begin
      even_next.colour = vsrf_colour_at(col_word, {ophase_reg[1:0], 1'b0});
      even_next.overlay = vsrf_overlay_at(ovl_word, ovl_idx);
      odd_next.colour = vsrf_colour_at(col_word, {ophase_reg[1:0], 1'b1});
      odd_next.overlay = vsrf_overlay_at(ovl_word, ovl_idx + 4'h1);
    end
    if (!fifo_unload_gate) begin
      ulat_next = '0;
      reading_next = 1'b0;
      rphase_next = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ulat_reg <= '0;
      reading_reg <= 1'b0;
      rphase_reg <= '0;
      ophase_reg <= '0;
      ovalid_reg <= 1'b0;
      outv_reg <= 1'b0;
      even_reg <= '0;
      odd_reg <= '0;
    end else begin
      ulat_reg <= ulat_next;
      reading_reg <= reading_next;
      rphase_reg <= rphase_next;
      ophase_reg <= ophase_next;
      ovalid_reg <= ovalid_next;
      outv_reg <= outv_next;
      even_reg <= even_next;
      odd_reg <= odd_next;
    end
  end

  assign merged_pixel_port_even = even_reg;
  assign merged_pixel_port_odd = odd_reg;
  assign pixel_valid = outv_reg && fifo_unload_gate;

  // ----------------------------------------------------------------
  // FIFOs; fill levels rely on the controller timing alone
  // ----------------------------------------------------------------
  vsrf_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) u_overlay_fifo (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clear(gate_off),
    .wr_valid(ovl_wr),
    .wr_data(lanes_s2_reg),
    .rd_pop(ovl_pop),
    .rd_data(ovl_word),
    .level(overlay_level),
    .full(),
    .empty()
  );

  // Colour FIFO deep enough to bridge the overlay fetch
  vsrf_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) u_colour_fifo (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clear(gate_off),
    .wr_valid(col_wr),
    .wr_data(lanes_s2_reg),
    .rd_pop(col_pop),
    .rd_data(col_word),
    .level(colour_level),
    .full(),
    .empty()
  );

endmodule : vsrf_top

//--- verification/testbench.sv
// Self-checking bench for the serial read FIFO block
`timescale 1ns/100ps
bind vsrf_top vsrf_asserts u_vsrf_asserts (.clk_sys(clk_sys), .reset_n(reset_n),
  .serial_read_gate(serial_read_gate), .fifo_unload_gate(fifo_unload_gate),
  .vram_shift_clock_a(vram_shift_clock_a), .vram_shift_clock_b(vram_shift_clock_b),
  .pixel_valid(pixel_valid), .overlay_level(overlay_level), .colour_level(colour_level));
module testbench
  import vsrf_pkg::*;
;
  // ----------------------------------------------------------------
  // Stimulus, scoreboard and verdict
  // ----------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic serial_read_gate = 1'b0;
  logic fifo_unload_gate = 1'b0;
  logic sc_a;
  logic sc_b;
  logic pixel_valid;
  vsrf_pixel_t px_even;
  vsrf_pixel_t px_odd;
  logic [3:0] overlay_level;
  logic [3:0] colour_level;
  vsrf_lanes_t lanes;
  vsrf_lanes_t cur_word;
  logic [5:0] word_idx;
  vsrf_lanes_t words [64];
  logic [23:0] exp_q [$];
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  always #25 clk_sys = ~clk_sys;
  assign cur_word = words[word_idx];
  vsrf_top u_vsrf_top (.clk_sys(clk_sys), .reset_n(reset_n), .serial_read_gate(serial_read_gate),
    .fifo_unload_gate(fifo_unload_gate), .vram_lane_a_even(lanes.a_even), .vram_lane_a_odd(lanes.a_odd),
    .vram_lane_b_even(lanes.b_even), .vram_lane_b_odd(lanes.b_odd), .vram_lane_c_even(lanes.c_even),
    .vram_lane_c_odd(lanes.c_odd), .vram_lane_d_even(lanes.d_even), .vram_lane_d_odd(lanes.d_odd),
    .vram_shift_clock_a(sc_a), .vram_shift_clock_b(sc_b), .merged_pixel_port_even(px_even),
    .merged_pixel_port_odd(px_odd), .pixel_valid(pixel_valid), .overlay_level(overlay_level),
    .colour_level(colour_level));
  // A new scan line restarts the VRAM row, so the model follows the gate
  vsrf_vram_model u_vram (.clk_sys(clk_sys), .restart(!serial_read_gate), .shift(sc_a),
    .word_in(cur_word), .lanes(lanes), .word_idx(word_idx));
  task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test
  // Pixel p of a group: overlay nibble from word p/16, colour byte from word 4+p/8
  function automatic logic [11:0] pix(input int base, input int p);
    logic [63:0] ow;
    logic [63:0] cw;
    ow = words[base + p / 16];
    cw = words[base + 4 + p / 8];
    return {ow[4 * (p % 16) +: 4], cw[8 * (p % 8) +: 8]};
  endfunction : pix
  // One line: fill, unload two groups, then close the line
  task automatic run_line(input int delay);
    serial_read_gate = 1'b1;
    repeat (delay) @(negedge clk_sys);
    chk("overlay fill", 24'(overlay_level), 24'h4);
    for (int g = 0; g < 2; g++) begin
      for (int p = 0; p < 64; p += 2) begin
        exp_q.push_back({pix(12 * g, p), pix(12 * g, p + 1)});
      end
    end
    fifo_unload_gate = 1'b1;
    for (int n = 0; n < 200 && exp_q.size() != 0; n++) @(negedge clk_sys);
    chk("pairs left", 24'(exp_q.size()), 24'h0);
    fifo_unload_gate = 1'b0;
    @(negedge clk_sys);
    serial_read_gate = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk("colour clear", 24'(colour_level), 24'h0);
    $display("test line done");
  endtask : run_line
  // Monitor: each valid pair consumes the oldest expected note
  always @(posedge clk_sys) begin
    if (pixel_valid === 1'b1 && exp_q.size() != 0) begin
      chk("pixel pair", {px_even, px_odd}, exp_q.pop_front());
    end else if (pixel_valid === 1'b1) begin
      chk("extra pair", 24'h1, 24'h0);
    end
  end
  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      finish_test();
    end
  end
  initial begin
    void'($urandom(32'h7ae6));
    for (int k = 0; k < 64; k++) words[k] = {$urandom, $urandom};
    repeat (8) @(negedge clk_sys);
    reset_n = 1'b1;
    @(negedge clk_sys);
    serial_read_gate = 1'b1;
    repeat ($urandom_range(40, 20)) @(negedge clk_sys);
    serial_read_gate = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk("abort clear", 24'(colour_level), 24'h0);
    $display("test abort done");
    run_line(31);
    serial_read_gate = 1'b1;
    repeat (25) @(negedge clk_sys);
    reset_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("reset state", {sc_a, sc_b, pixel_valid, 13'h0, overlay_level, colour_level}, 24'h0);
    serial_read_gate = 1'b0;
    reset_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    $display("test reset done");
    run_line($urandom_range(32, 30));
    finish_test();
  end
endmodule : testbench

//--- verification/vsrf_asserts.sv
// Concurrent checks on shift clock, FIFO levels and pixel valid of the serial read block
`timescale 1ns/100ps
module vsrf_asserts
  import vsrf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic serial_read_gate,
  input wire logic fifo_unload_gate,
  input wire logic vram_shift_clock_a,
  input wire logic vram_shift_clock_b,
  input wire logic pixel_valid,
  input wire logic [3:0] overlay_level,
  input wire logic [3:0] colour_level
);
  // ----------------------------------------------------------------
  // Group position tracker
  // ----------------------------------------------------------------
  logic [3:0] pcnt_reg;
  logic sc;
  assign sc = vram_shift_clock_a;
  // Pulse index inside a 12-read group, cleared with the gate
  always_ff @(posedge clk_sys) begin
    if (!reset_n || !serial_read_gate) begin
      pcnt_reg <= 4'h0;
    end else if (sc) begin
      pcnt_reg <= (pcnt_reg == 4'hb) ? 4'h0 : pcnt_reg + 4'h1;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_shift_pair: assert property (vram_shift_clock_a == vram_shift_clock_b)
    else $error("shift clock outputs differ");
  a_gate_quiet: assert property (!serial_read_gate |=> !sc)
    else $error("shift pulse without serial gate");
  a_fetch_start: assert property (disable iff (!reset_n || !serial_read_gate) $rose(serial_read_gate) |-> (!sc)[*8] ##[1:2] sc)
    else $error("first shift pulse at wrong time");
  // Gate drop mid-group abandons the attempt rather than flagging it
  a_pulse_gap: assert property (disable iff (!reset_n || !serial_read_gate) sc && pcnt_reg != 4'hb |=> !sc ##[1:2] sc)
    else $error("shift pulse spacing wrong");
  a_group_skip: assert property (disable iff (!reset_n || !serial_read_gate) sc && pcnt_reg == 4'hb |=> (!sc)[*4] ##1 sc)
    else $error("no skipped pulse after group");
  a_unload_lat: assert property (disable iff (!reset_n || !fifo_unload_gate) $rose(fifo_unload_gate) |-> (!pixel_valid)[*4] ##[1:2] pixel_valid)
    else $error("pixel valid at wrong time");
  a_valid_gate: assert property (!fifo_unload_gate |-> !pixel_valid)
    else $error("pixel valid without unload gate");
  a_level_max: assert property (overlay_level <= 4'h8 && colour_level <= 4'h8)
    else $error("FIFO level above depth");
  a_gate_clear: assert property ($fell(serial_read_gate) |-> ##[1:2] (overlay_level == 4'h0 && colour_level == 4'h0))
    else $error("FIFOs not cleared by gate");
  a_ovl_write: assert property (disable iff (!reset_n || !serial_read_gate) sc && pcnt_reg < 4'h4 && !fifo_unload_gate |-> ##3 overlay_level == $past(overlay_level) + 4'h1)
    else $error("overlay read not stored");
  a_col_write: assert property (disable iff (!reset_n || !serial_read_gate) sc && pcnt_reg > 4'h3 && !fifo_unload_gate |-> ##3 colour_level == $past(colour_level) + 4'h1)
    else $error("colour read not stored");
  c_group_skip: cover property (sc && pcnt_reg == 4'hb);
  c_unload: cover property ($rose(fifo_unload_gate));
  c_abort: cover property ($fell(serial_read_gate) && colour_level != 4'h0);
endmodule : vsrf_asserts

//--- verification/vsrf_vram_model.sv
// Behavioural VRAM serial port model driving the eight lanes
`timescale 1ns/100ps
module vsrf_vram_model
  import vsrf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic restart,
  input wire logic shift,
  input wire vsrf_lanes_t word_in,
  output vsrf_lanes_t lanes,
  output logic [5:0] word_idx
);
  // ----------------------------------------------------------------
  // Serial port
  // ----------------------------------------------------------------
  // Current word stands on the pins; a pulse takes it and the port moves on
  assign lanes = word_in;
  // Advance only after the pulse edge, so the device latches the word it saw
  always @(posedge clk_sys) begin
    if (restart) begin
      word_idx <= 6'h0;
    end else if (shift) begin
      word_idx <= word_idx + 6'h1;
    end
  end
endmodule : vsrf_vram_model
